// ### rtl/epv_pkg.sv
// Constants and state codes of the EPROM program/verify port.
// Assumes one reference clock that also serves as the oscillator clock.
package epv_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;

   // ------------------------------------------------------------
   // Addresses and codes
   // ------------------------------------------------------------
   localparam logic [15:0] BOOT_START_ADDR = 16'hffe0;
   localparam logic [7:0] PV_SELECTOR = 8'he1;
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [2:0] PMODE_INTERNAL = 3'h6;
   localparam logic [2:0] PMODE_PROTECTED = 3'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLKS_PER_TCY = 4;
   localparam int SAMPLE_DELAY_TCY = 3;
   localparam int SAMPLE_DELAY_CLKS = SAMPLE_DELAY_TCY * CLKS_PER_TCY;
   localparam int FETCH_CLKS = 2;
   localparam int CNT_W = 4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] PC_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [9:0] {
      ST_HELD   = 10'h001,
      ST_NORMAL = 10'h002,
      ST_SELECT = 10'h004,
      ST_LOAD   = 10'h008,
      ST_LOADED = 10'h010,
      ST_VREADY = 10'h020,
      ST_FETCH  = 10'h040,
      ST_VOUT   = 10'h080,
      ST_VDONE  = 10'h100,
      ST_PROG   = 10'h200
   } epv_state_t;

endpackage

// ### rtl/epv_mem.sv
// Word-wide EPROM array with a registered read port.
// Assumes a write only clears bits, as an EPROM cell can only be programmed.
`timescale 1ns/100ps
module epv_mem #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input wire logic ref_clk,
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [DATA_W-1:0] rd_data_q,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data
);

   logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

   // Starts erased; a real array powers up in whatever state UV left it.
   initial begin
      for (int i = 0; i < (1 << ADDR_W); i++) begin
         cells[i] = epv_pkg::ERASED_WORD[DATA_W-1:0];
      end
   end

   // Programming pulls bits to zero and never sets them back.
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= cells[wr_addr] & wr_data;
      end
      rd_data_q <= cells[rd_addr];
   end

endmodule

// ### rtl/epv_port.sv
// Program/verify port sequencer of the on-chip EPROM.
// Assumes pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
module epv_port #(
   parameter int ADDR_W = 16
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic test_pin,
   input wire logic master_clear_pin,
   input wire logic entry_select_two,
   input wire logic entry_select_three,
   input wire logic entry_select_four,
   input wire logic program_strobe,
   input wire logic address_verify_strobe,
   input wire logic [7:0] high_byte_port_in,
   input wire logic [7:0] low_byte_port_in,
   input wire logic [2:0] cfg_processor_mode,
   output logic [7:0] high_byte_port_out,
   output logic high_byte_port_oe,
   output logic [7:0] low_byte_port_out,
   output logic low_byte_port_oe,
   output logic prog_mode,
   output logic [15:0] program_counter,
   output logic [2:0] eff_processor_mode,
   output logic power_up_delay_timer_bypass,
   output logic oscillator_startup_timer_bypass,
   output logic programming_active
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   localparam int NSYNC = 23;
   logic [NSYNC-1:0] pins_raw, sync1_q, sync2_q;
   assign pins_raw = {test_pin, master_clear_pin, entry_select_two,
                      entry_select_three, entry_select_four,
                      program_strobe, address_verify_strobe,
                      high_byte_port_in, low_byte_port_in};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   logic test_s, master_clear_pin_s, sel2_s, sel3_s, sel4_s, pgm_s, av_s;
   logic [7:0] hi_s, lo_s;
   assign {test_s, master_clear_pin_s, sel2_s, sel3_s, sel4_s, pgm_s, av_s,
           hi_s, lo_s} = sync2_q;

   // ------------------------------------------------------------
   // Strobe edge detection
   // ------------------------------------------------------------
   logic pgm_prev_q, av_prev_q;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pgm_prev_q <= 1'b0;
         av_prev_q <= 1'b0;
      end else begin
         pgm_prev_q <= pgm_s;
         av_prev_q <= av_s;
      end
   end

   logic pgm_rise, pgm_fall, av_rise, av_fall;
   assign pgm_rise = pgm_s & ~pgm_prev_q;
   assign pgm_fall = ~pgm_s & pgm_prev_q;
   assign av_rise = av_s & ~av_prev_q;
   assign av_fall = ~av_s & av_prev_q;

   // ------------------------------------------------------------
   // Array
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [15:0] rd_data;
   logic wr_en;
   logic [15:0] wr_data;

   epv_mem #(
      .ADDR_W(ADDR_W),
      .DATA_W(epv_pkg::DATA_W)
   ) u_mem (
      .ref_clk(ref_clk),
      .rd_addr(addr_q),
      .rd_data_q(rd_data),
      .wr_en(wr_en),
      .wr_addr(addr_q),
      .wr_data(wr_data)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   epv_pkg::epv_state_t state_q, state_d;
   logic [epv_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic entry_ok_q, entry_ok_d;
   logic av_early_q, av_early_d;
   logic sampled_q, sampled_d;
   logic prog_mode_q, prog_mode_d;
   logic [15:0] pc_q, pc_d;
   logic [7:0] hi_out_q, hi_out_d, lo_out_q, lo_out_d;
   logic oe_q, oe_d;
   logic pgm_act_q, pgm_act_d;
   logic [2:0] pmode_q, pmode_d;
   logic power_up_delay_timer_byp_q, power_up_delay_timer_byp_d, ost_byp_q, ost_byp_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      entry_ok_d = entry_ok_q;
      av_early_d = av_early_q;
      sampled_d = sampled_q;
      prog_mode_d = prog_mode_q;
      pc_d = pc_q;
      hi_out_d = hi_out_q;
      lo_out_d = lo_out_q;
      oe_d = 1'b0;
      pgm_act_d = 1'b0;
      wr_en = 1'b0;
      wr_data = {hi_s, lo_s};
      power_up_delay_timer_byp_d = test_s;
      ost_byp_d = test_s;
      if (prog_mode_q && cfg_processor_mode != epv_pkg::PMODE_PROTECTED) begin
         pmode_d = epv_pkg::PMODE_INTERNAL;
      end else begin
         pmode_d = cfg_processor_mode;
      end
      if (!master_clear_pin_s) begin
         state_d = epv_pkg::ST_HELD;
         prog_mode_d = 1'b0;
         entry_ok_d = test_s & ~sel2_s & ~sel3_s & sel4_s;
      end else begin
         unique case (state_q)
            epv_pkg::ST_HELD: begin
               if (entry_ok_q) begin
                  pc_d = epv_pkg::BOOT_START_ADDR;
                  prog_mode_d = 1'b1;
                  state_d = epv_pkg::ST_SELECT;
               end else begin
                  state_d = epv_pkg::ST_NORMAL;
               end
            end
            epv_pkg::ST_NORMAL: begin
               state_d = epv_pkg::ST_NORMAL;
            end
            epv_pkg::ST_SELECT: begin
               if (hi_s == epv_pkg::PV_SELECTOR) begin
                  state_d = epv_pkg::ST_LOAD;
               end
            end
            epv_pkg::ST_LOAD: begin
               if (av_rise) begin
                  addr_d = ADDR_W'({hi_s, lo_s});
                  state_d = epv_pkg::ST_LOADED;
               end
            end
            epv_pkg::ST_LOADED: begin
               if (av_fall) begin
                  state_d = epv_pkg::ST_VREADY;
               end
            end
            epv_pkg::ST_VREADY: begin
               if (av_rise) begin
                  cnt_d = '0;
                  state_d = epv_pkg::ST_FETCH;
               end else if (pgm_rise) begin
                  cnt_d = '0;
                  sampled_d = 1'b0;
                  av_early_d = 1'b0;
                  state_d = epv_pkg::ST_PROG;
               end
            end
            epv_pkg::ST_FETCH: begin
               // The registered read port needs one clock; FETCH waits two before its word is used.
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == epv_pkg::CNT_W'(epv_pkg::FETCH_CLKS - 1)) begin
                  state_d = epv_pkg::ST_VOUT;
               end
            end
            epv_pkg::ST_VOUT: begin
               hi_out_d = rd_data[15:8];
               lo_out_d = rd_data[7:0];
               oe_d = 1'b1;
               if (!av_s) begin
                  oe_d = 1'b0;
                  state_d = epv_pkg::ST_VDONE;
               end
            end
            epv_pkg::ST_VDONE: begin
               if (av_rise) begin
                  addr_d = addr_q + 1'b1;
                  cnt_d = '0;
                  state_d = epv_pkg::ST_FETCH;
               end else if (pgm_rise) begin
                  cnt_d = '0;
                  sampled_d = 1'b0;
                  av_early_d = 1'b0;
                  state_d = epv_pkg::ST_PROG;
               end
            end
            epv_pkg::ST_PROG: begin
               pgm_act_d = pgm_s;
               if (!sampled_q) begin
                  cnt_d = cnt_q + 1'b1;
                  if (cnt_q ==
                      epv_pkg::CNT_W'(epv_pkg::SAMPLE_DELAY_CLKS - 1)) begin
                     wr_en = 1'b1;
                     sampled_d = 1'b1;
                  end
               end
               if (av_rise) begin
                  av_early_d = 1'b1;
               end
               if (pgm_fall) begin
                  pgm_act_d = 1'b0;
                  cnt_d = '0;
                  if (av_early_q || av_rise) begin
                     state_d = epv_pkg::ST_FETCH;
                  end else begin
                     state_d = epv_pkg::ST_VDONE;
                  end
               end
            end
            default: begin
               state_d = epv_pkg::ST_HELD;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= epv_pkg::ST_HELD;
         cnt_q <= '0;
         addr_q <= epv_pkg::ADDR_RESET[ADDR_W-1:0];
         entry_ok_q <= 1'b0;
         av_early_q <= 1'b0;
         sampled_q <= 1'b0;
         prog_mode_q <= 1'b0;
         pc_q <= epv_pkg::PC_RESET;
         hi_out_q <= '0;
         lo_out_q <= '0;
         oe_q <= 1'b0;
         pgm_act_q <= 1'b0;
         pmode_q <= '0;
         power_up_delay_timer_byp_q <= 1'b0;
         ost_byp_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         entry_ok_q <= entry_ok_d;
         av_early_q <= av_early_d;
         sampled_q <= sampled_d;
         prog_mode_q <= prog_mode_d;
         pc_q <= pc_d;
         hi_out_q <= hi_out_d;
         lo_out_q <= lo_out_d;
         oe_q <= oe_d;
         pgm_act_q <= pgm_act_d;
         pmode_q <= pmode_d;
         power_up_delay_timer_byp_q <= power_up_delay_timer_byp_d;
         ost_byp_q <= ost_byp_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign high_byte_port_out = hi_out_q;
   assign low_byte_port_out = lo_out_q;
   assign high_byte_port_oe = oe_q;
   assign low_byte_port_oe = oe_q;
   assign prog_mode = prog_mode_q;
   assign program_counter = pc_q;
   assign eff_processor_mode = pmode_q;
   assign power_up_delay_timer_bypass = power_up_delay_timer_byp_q;
   assign oscillator_startup_timer_bypass = ost_byp_q;
   assign programming_active = pgm_act_q;

endmodule

// ### tb/epv_port_asserts.sv
// Concurrent checks on the ports of the program/verify sequencer.
// Assumes it is bound to epv_port and sees only its ports.
`timescale 1ns/100ps
module epv_port_asserts (
   input logic ref_clk,
   input logic rst_n,
   input logic test_pin,
   input logic program_strobe,
   input logic address_verify_strobe,
   input logic [2:0] cfg_processor_mode,
   input logic high_byte_port_oe,
   input logic low_byte_port_oe,
   input logic prog_mode,
   input logic [15:0] program_counter,
   input logic [2:0] eff_processor_mode,
   input logic power_up_delay_timer_bypass,
   input logic oscillator_startup_timer_bypass,
   input logic programming_active
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Pin changes take about three clocks to act, hence the slack below.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   oe_pair_a:
      assert property (high_byte_port_oe == low_byte_port_oe)
      else $error("port enables differ");
   oe_cause_a:
      assert property ($rose(high_byte_port_oe) |-> $past(address_verify_strobe, 3))
      else $error("ports driven without verify strobe");
   oe_release_a:
      assert property ($fell(address_verify_strobe) |-> ##[2:6] !high_byte_port_oe)
      else $error("ports still driven after verify");
   prog_quiet_a:
      assert property (programming_active |-> !high_byte_port_oe)
      else $error("ports driven while programming");
   prog_start_a:
      assert property ($rose(program_strobe) && prog_mode |-> ##[2:5] programming_active)
      else $error("program cycle did not start");
   prog_stop_a:
      assert property ($fell(program_strobe) |-> ##[1:5] !programming_active)
      else $error("programming outlived strobe");
   prog_hold_a:
      assert property (program_strobe [*4] ##0 programming_active |=> programming_active)
      else $error("programming ended early");
   boot_pc_a:
      assert property ($rose(prog_mode) |-> program_counter == 16'hffe0)
      else $error("wrong boot start address");
   mode_force_a:
      assert property ((prog_mode && cfg_processor_mode != 3'h0) [*2] |-> eff_processor_mode == 3'h6)
      else $error("internal execution not forced");
   protect_kept_a:
      assert property ((prog_mode && cfg_processor_mode == 3'h0) [*2] |-> eff_processor_mode == 3'h0)
      else $error("code protection lost");
   timer_bypass_a:
      assert property (test_pin [*5] |-> power_up_delay_timer_bypass && oscillator_startup_timer_bypass)
      else $error("start-up timers not bypassed");
endmodule

// ### tb/epv_programmer.sv
// Behavioural model of the device programmer at the port pins.
// Assumes the bench calls its tasks one at a time, just after an edge.
`timescale 1ns/100ps
module epv_programmer (
   input wire logic ref_clk,
   input wire logic [7:0] hi_out,
   input wire logic hi_oe,
   input wire logic [7:0] lo_out,
   input wire logic lo_oe,
   output logic test_pin,
   output logic master_clear_pin,
   output logic sel_two,
   output logic sel_three,
   output logic sel_four,
   output logic program_strobe,
   output logic address_verify_strobe,
   output logic [7:0] hi_wire,
   output logic [7:0] lo_wire
);
   // ------------------------------------------------------------
   // Pins and tasks
   // ------------------------------------------------------------
   // Every strobe level lasts at least 11 Tcy, one above the minimum; both strobes stay high 12 Tcy in a burn that verifies the same word.
   localparam int HOLD = 44;
   logic drv;
   logic [15:0] word;
   logic [7:0] lo_last = 8'h00;
   initial begin
      {test_pin, master_clear_pin, sel_two, sel_three, sel_four} = 5'h00;
      {program_strobe, address_verify_strobe, drv} = 3'h0;
      word = 16'h0000;
   end
   // The high port has pull-ups; a floating low port must not look valid.
   always_comb begin
      hi_wire = hi_oe ? hi_out : (drv ? word[15:8] : 8'hff);
      lo_wire = lo_oe ? lo_out : (drv ? word[7:0] : ~lo_last);
   end
   always @(posedge ref_clk) if (lo_oe | drv) lo_last <= lo_wire;
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic put(input logic [15:0] w);
      word = w;
      drv = 1'b1;
   endtask
   // straps held, then a clean clear edge
   // Straps are given as test, select two, select three, select four.
   task automatic enter(input logic [3:0] straps);
      {test_pin, sel_two, sel_three, sel_four} = straps;
      tick(10);
      master_clear_pin = 1'b1;
      tick(HOLD);
   endtask
   // reset is the only way back to an address load
   task automatic leave();
      {master_clear_pin, drv} = 2'b00;
      tick(10);
   endtask
   // branch selector on the high port
   task automatic select(input logic [7:0] v);
      put({v, 8'h00});
      tick(20);
   endtask
   // address on both ports, long strobe levels
   task automatic load(input logic [15:0] a);
      put(a);
      address_verify_strobe = 1'b1;
      tick(HOLD);
      address_verify_strobe = 1'b0;
      tick(HOLD);
   endtask
   task automatic verify(output logic [15:0] w, output logic ok);
      drv = 1'b0;
      address_verify_strobe = 1'b1;
      tick(HOLD);
      ok = hi_oe;
      w = {hi_wire, lo_wire};
      address_verify_strobe = 1'b0;
      tick(HOLD);
   endtask
   task automatic burn(input logic [15:0] d, input logic same,
      output logic [15:0] w, output logic ok);
      {w, ok} = 17'h1;
      put(d);
      tick(2);
      program_strobe = 1'b1;
      tick(20);
      // Junk after the sampling point shows whether the word was taken late.
      put(~d);
      tick(HOLD - 20);
      drv = 1'b0;
      if (same) begin
         // verify strobe rises before the program strobe falls
         address_verify_strobe = 1'b1;
         tick(4);
         program_strobe = 1'b0;
         tick(HOLD);
         ok = hi_oe;
         w = {hi_wire, lo_wire};
         address_verify_strobe = 1'b0;
      end else
         program_strobe = 1'b0;
      tick(HOLD);
   endtask
endmodule

// ### tb/epv_port_tb.sv
// Self-checking bench of the program/verify port.
// Assumes the programmer model drives every pin of the port.
`timescale 1ns/100ps
module epv_port_tb;
   // ------------------------------------------------------------
   // Harness
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] op;
      logic [15:0] d;
      logic [15:0] e;
   } epv_row_t;
   // Row kinds: 0 verify, 1 program then verify same, 2 program then
   // verify next, 3 program and stay.
   // Blank check first.
   localparam epv_row_t ROWS [6] = '{'{2'd0, 16'h0, 16'hffff},
      '{2'd1, 16'ha5c3, 16'ha5c3}, '{2'd3, 16'h0ff0, 16'h0},
      '{2'd1, 16'hf0ff, 16'h00c0}, '{2'd0, 16'h0, 16'hffff},
      '{2'd2, 16'h1234, 16'hffff}};
   // Each pattern breaks one entry strap: test low, select three high,
   // select two high, select four low.
   localparam logic [3:0] BAD [4] = '{4'h1, 4'hb, 4'hd, 4'h8};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] cfg = 3'h7;
   logic tp, mc, s2, s3, s4, ps, av, hoe, loe, pm, b0, b1, pa;
   logic [7:0] hi, lo, ho, lq;
   logic [15:0] pc;
   logic [2:0] em;
   int mismatches = 0;
   int checks = 0;
   `define CHK(a, b) begin checks++; if ((a) !== (b)) begin \
      $display("CHECK FAILED %0t got %h exp %h", $time, a, b); \
      mismatches++; end end
   initial forever #20 ref_clk = ~ref_clk;
   epv_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .test_pin(tp),
      .master_clear_pin(mc), .entry_select_two(s2),
      .entry_select_three(s3), .entry_select_four(s4),
      .program_strobe(ps), .address_verify_strobe(av),
      .high_byte_port_in(hi), .low_byte_port_in(lo),
      .cfg_processor_mode(cfg), .high_byte_port_out(ho),
      .high_byte_port_oe(hoe), .low_byte_port_out(lq),
      .low_byte_port_oe(loe), .prog_mode(pm), .program_counter(pc),
      .eff_processor_mode(em), .power_up_delay_timer_bypass(b0),
      .oscillator_startup_timer_bypass(b1), .programming_active(pa));
   epv_programmer prog (.ref_clk(ref_clk), .hi_out(ho), .hi_oe(hoe),
      .lo_out(lq), .lo_oe(loe), .test_pin(tp), .master_clear_pin(mc),
      .sel_two(s2), .sel_three(s3), .sel_four(s4), .program_strobe(ps),
      .address_verify_strobe(av), .hi_wire(hi), .lo_wire(lo));
   task automatic conclude();
      if (mismatches == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic step(input epv_row_t r, output logic [15:0] w,
      output logic ok);
      {w, ok} = 17'h1;
      if (r.op == 2'd1)
         prog.burn(r.d, 1'b1, w, ok);
      else begin
         if (r.op != 2'd0) prog.burn(r.d, 1'b0, w, ok);
         if (r.op != 2'd3) prog.verify(w, ok);
      end
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      logic [15:0] w;
      logic ok;
      int n;
      repeat (10) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      prog.enter(4'h9);
      `CHK(pm, 1'b1)
      `CHK(pc, 16'hffe0)
      `CHK(em, 3'h6)
      `CHK(b0 & b1, 1'b1)
      prog.select(8'he1);
      prog.load(16'h0100);
      for (int i = 0; i < 6; i++) begin
         step(ROWS[i], w, ok);
         if (ROWS[i].op != 2'd3) begin
            `CHK(ok, 1'b1)
            `CHK(w, ROWS[i].e)
         end
      end
      // A new address needs master clear and a fresh entry.
      prog.leave();
      `CHK(pm | hoe, 1'b0)
      cfg = 3'h0;
      prog.enter(4'h9);
      `CHK(em, 3'h0)
      prog.select(8'he1);
      prog.load(16'h0101);
      prog.verify(w, ok);
      `CHK(w, 16'h1234)
      n = 0;
      do begin
         prog.burn(16'h1230, 1'b1, w, ok);
         n++;
      end while (w !== 16'h1230 && n < 100);
      `CHK(n, 1)
      `CHK(w, 16'h1230)
      foreach (BAD[k]) begin
         prog.leave();
         prog.enter(BAD[k]);
         `CHK(pm, 1'b0)
         `CHK(b0 | b1, BAD[k][3])
      end
      prog.leave();
      prog.enter(4'h9);
      rst_n = 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK({pm, pc}, 17'h0)
      rst_n = 1'b1;
      conclude();
   end
   initial begin
      #400000;
      mismatches++;
      conclude();
   end
endmodule
bind epv_port epv_port_asserts chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .test_pin(test_pin), .program_strobe(program_strobe),
   .address_verify_strobe(address_verify_strobe),
   .cfg_processor_mode(cfg_processor_mode),
   .high_byte_port_oe(high_byte_port_oe),
   .low_byte_port_oe(low_byte_port_oe), .prog_mode(prog_mode),
   .program_counter(program_counter),
   .eff_processor_mode(eff_processor_mode),
   .power_up_delay_timer_bypass(power_up_delay_timer_bypass),
   .oscillator_startup_timer_bypass(oscillator_startup_timer_bypass),
   .programming_active(programming_active));
